// [logic/nvp_pkg.sv]
// shared constants and types for the partitioned nv sram host port
package nvp_pkg;

    // ************************************************************
    // pin geometry
    // ************************************************************
    localparam int ADDR_W       = 17;                // word address pins
    localparam int DATA_W       = 16;                // data pins
    localparam int PART_LSB     = 13;                // partition field low bit
    localparam int PART_W       = 4;                 // partition field width
    localparam int PART_COUNT   = 16;                // protectable partitions
    localparam int MATCH_READS  = 20;                // pattern reads
    localparam int LOAD_READS   = 4;                 // register load reads
    localparam int TOTAL_READS  = MATCH_READS + LOAD_READS;
    localparam int STEP_W       = 5;                 // holds 0..23

    // ************************************************************
    // timing in ns, converted to 200 MHz cycles
    // ************************************************************
    localparam int CLK_PERIOD_NS       = 5;
    localparam int T_ADDR_SETUP_NS     = 0;
    localparam int T_ACCESS_NS         = 70;
    localparam int T_CE_PULSE_NS       = 75;
    localparam int T_WRITE_PULSE_NS    = 55;
    localparam int T_ADDR_HOLD_NS      = 50;
    localparam int T_READ_RECOVERY_NS  = 20;
    localparam int T_WRITE_RECOVERY_NS = 10;

    // least time: round up, never below one cycle
    function automatic int min_cycles(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int max_of(input int a, input int b);
        return (a > b) ? a : b;
    endfunction

    localparam int SETUP_CYC    = min_cycles(T_ADDR_SETUP_NS);
    localparam int READ_CYC     = min_cycles(max_of(T_ACCESS_NS, T_CE_PULSE_NS));
    localparam int WRITE_CYC    = min_cycles(T_WRITE_PULSE_NS);
    localparam int RECOVER_CYC  = min_cycles(max_of(T_ADDR_HOLD_NS,
                                  max_of(T_READ_RECOVERY_NS, T_WRITE_RECOVERY_NS)));
    localparam int TIMER_W      = 5;

    // ************************************************************
    // unlock pattern on addr[16:13], last read first (first read in the low nibble)
    // ************************************************************
    localparam logic [MATCH_READS*PART_W-1:0] UNLOCK_PATTERN = {
        4'h5, 4'h0, 4'h1, 4'h9, 4'h6, 4'hA, 4'h4, 4'h2, 4'h4, 4'h9,
        4'h3, 4'h7, 4'hE, 4'hC, 4'h9, 4'h3, 4'h7, 4'h7, 4'hE, 4'hF
    };

    // ************************************************************
    // commands and states
    // ************************************************************
    typedef enum logic [1:0] {
        NVP_CMD_READ,
        NVP_CMD_WRITE,
        NVP_CMD_PROTECT,
        NVP_CMD_NONE
    } nvp_cmd_t;

    typedef enum logic [1:0] {
        NVP_IDLE,
        NVP_SETUP,
        NVP_STROBE,
        NVP_RECOVER
    } nvp_state_t;

endpackage

// [logic/nvp_phase_timer.sv]
// phase timer: one-cycle tick at the end of a loaded phase length
`timescale 1ns/100ps
module nvp_phase_timer #(
    parameter int WIDTH = 5
) (
    // clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    // phase control
    input  wire logic             start_in,
    input  wire logic [WIDTH-1:0] len_in,
    output logic                  tick_out
);

    typedef struct packed {
        logic [WIDTH-1:0] count;
    } nvp_timer_t;

    nvp_timer_t tmr_reg;
    nvp_timer_t tmr_next;

    // ************************************************************
    // countdown; a start restarts even a running phase
    // ************************************************************
    always_comb begin
        tmr_next = tmr_reg;
        if (start_in) begin
            tmr_next.count = len_in;
        end else if (tmr_reg.count != '0) begin
            tmr_next.count = tmr_reg.count - WIDTH'(1);
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            tmr_reg <= '0;
        end else begin
            tmr_reg <= tmr_next;
        end
    end

    // phase of length n ticks n cycles after the start pulse
    // no start term here: the sequencer raises start from this tick
    assign tick_out = (tmr_reg.count == WIDTH'(1));

endmodule

// [logic/nvp_host_port.sv]
// host controller driving a partitioned nv sram through its pins
//
// Overview of operation
// - host holds every address bit steady through the whole write cycle.
// - host keeps output drive high during writes to avoid bus contention.
// - host reaches partition register by 20 word reads carrying a pattern.
// - pattern on address 16..13 is the fixed twenty-value sequence.
// - host discards data returned by the 24 programming reads.
`timescale 1ns/100ps
module nvp_host_port #(
    parameter int ADDR_W  = nvp_pkg::ADDR_W,
    parameter int DATA_W  = nvp_pkg::DATA_W,
    parameter int TIMER_W = nvp_pkg::TIMER_W
) (
    // clock and reset
    input  wire logic              clk_in,
    input  wire logic              rst_in,
    // user command port
    input  wire logic              cmd_valid_in,
    output logic                   cmd_ready_out,
    input  wire logic [1:0]        cmd_kind_in,
    input  wire logic [ADDR_W-1:0] cmd_addr_in,
    input  wire logic [DATA_W-1:0] cmd_wdata_in,
    input  wire logic [1:0]        cmd_byte_en_in,
    input  wire logic [15:0]       cmd_protect_mask_in,
    // user response port
    output logic                   rsp_valid_out,
    output logic                   rsp_abort_out,
    output logic [DATA_W-1:0]      rsp_rdata_out,
    // supply monitor
    input  wire logic              power_good_in,
    // memory pins
    output logic [ADDR_W-1:0]      word_address_pins_out,
    output logic                   upper_byte_select_n_out,
    output logic                   lower_byte_select_n_out,
    output logic                   write_strobe_n_out,
    output logic                   output_drive_n_out,
    input  wire logic [DATA_W-1:0] data_pins_in,
    output logic [DATA_W-1:0]      data_pins_out,
    output logic                   data_pins_oe_n_out
);

    // ************************************************************
    // elaboration checks
    // ************************************************************
    if (ADDR_W != nvp_pkg::ADDR_W || DATA_W != nvp_pkg::DATA_W) begin : g_bad_geom
        $error("pin widths must match the memory geometry");
    end
    if ((1 << TIMER_W) <= nvp_pkg::max_of(nvp_pkg::READ_CYC,
        nvp_pkg::max_of(nvp_pkg::WRITE_CYC, nvp_pkg::RECOVER_CYC))) begin : g_bad_timer
        $error("timer width too small for the phase lengths");
    end

    localparam logic [TIMER_W-1:0] SETUP_LEN   = TIMER_W'(nvp_pkg::SETUP_CYC);
    localparam logic [TIMER_W-1:0] READ_LEN    = TIMER_W'(nvp_pkg::READ_CYC);
    localparam logic [TIMER_W-1:0] WRITE_LEN   = TIMER_W'(nvp_pkg::WRITE_CYC);
    localparam logic [TIMER_W-1:0] RECOVER_LEN = TIMER_W'(nvp_pkg::RECOVER_CYC);
    localparam logic [nvp_pkg::STEP_W-1:0] LAST_STEP =
        nvp_pkg::STEP_W'(nvp_pkg::TOTAL_READS - 1);

    // ************************************************************
    // helpers
    // ************************************************************
    // address of a programming read: pattern value, then mask nibbles
    function automatic logic [ADDR_W-1:0] prog_addr(
        input logic [nvp_pkg::STEP_W-1:0] step,
        input logic [15:0]                mask
    );
        logic [nvp_pkg::PART_W-1:0] nib;
        int                         idx;
        idx = int'(step);
        if (idx < nvp_pkg::MATCH_READS) begin
            nib = nvp_pkg::UNLOCK_PATTERN[idx*nvp_pkg::PART_W +: nvp_pkg::PART_W];
        end else begin
            // addr13 carries the lowest partition of the group
            nib = mask[(idx - nvp_pkg::MATCH_READS)*nvp_pkg::PART_W +: nvp_pkg::PART_W];
        end
        prog_addr = '0;
        prog_addr[nvp_pkg::PART_LSB +: nvp_pkg::PART_W] = nib;
        return prog_addr;
    endfunction

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        nvp_pkg::nvp_state_t        state;
        nvp_pkg::nvp_cmd_t          kind;
        logic [nvp_pkg::STEP_W-1:0] step;
        logic [15:0]                mask;
        logic [1:0]                 byte_en;
        logic [ADDR_W-1:0]          addr;
        logic [DATA_W-1:0]          wdata;
        logic                       sel_u_n;
        logic                       sel_l_n;
        logic                       we_n;
        logic                       oe_n;
        logic                       drive_n;
        logic                       rsp_valid;
        logic                       rsp_abort;
        logic [DATA_W-1:0]          rdata;
    } nvp_host_t;

    nvp_host_t st_reg;
    nvp_host_t st_next;

    logic                 tmr_start;
    logic [TIMER_W-1:0]   tmr_len;
    logic                 tmr_tick;

    nvp_phase_timer #(
        .WIDTH    (TIMER_W)
    ) u_timer (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .start_in (tmr_start),
        .len_in   (tmr_len),
        .tick_out (tmr_tick)
    );

    // ************************************************************
    // access sequencer
    // ************************************************************
    // idle pins: all strobes high, data bus released
    always_comb begin
        st_next           = st_reg;
        st_next.rsp_valid = 1'b0;
        st_next.rsp_abort = 1'b0;
        tmr_start         = 1'b0;
        tmr_len           = SETUP_LEN;
        if (!power_good_in && st_reg.state != nvp_pkg::NVP_IDLE) begin
            // device ignores us now; drop the cycle rather than guess
            st_next.state     = nvp_pkg::NVP_IDLE;
            st_next.sel_u_n   = 1'b1;
            st_next.sel_l_n   = 1'b1;
            st_next.we_n      = 1'b1;
            st_next.oe_n      = 1'b1;
            st_next.drive_n   = 1'b1;
            st_next.rsp_valid = 1'b1;
            st_next.rsp_abort = 1'b1;
        end else begin
            unique case (st_reg.state)
                nvp_pkg::NVP_IDLE: begin
                    if (cmd_valid_in && power_good_in &&
                        nvp_pkg::nvp_cmd_t'(cmd_kind_in) != nvp_pkg::NVP_CMD_NONE) begin
                        st_next.kind    = nvp_pkg::nvp_cmd_t'(cmd_kind_in);
                        st_next.wdata   = cmd_wdata_in;
                        st_next.mask    = cmd_protect_mask_in;
                        st_next.step    = '0;
                        if (nvp_pkg::nvp_cmd_t'(cmd_kind_in) == nvp_pkg::NVP_CMD_PROTECT) begin
                            st_next.byte_en = 2'h3;
                            st_next.addr    = prog_addr('0, cmd_protect_mask_in);
                        end else begin
                            // no selects means no access; widen to a word
                            st_next.byte_en = (cmd_byte_en_in == 2'h0) ? 2'h3 : cmd_byte_en_in;
                            st_next.addr    = cmd_addr_in;
                        end
                        st_next.drive_n = (nvp_pkg::nvp_cmd_t'(cmd_kind_in) !=
                                           nvp_pkg::NVP_CMD_WRITE);
                        st_next.state   = nvp_pkg::NVP_SETUP;
                        tmr_start       = 1'b1;
                        tmr_len         = SETUP_LEN;
                    end
                end
                nvp_pkg::NVP_SETUP: begin
                    if (tmr_tick) begin
                        // address already stable for the setup phase
                        st_next.sel_u_n = !st_reg.byte_en[1];
                        st_next.sel_l_n = !st_reg.byte_en[0];
                        if (st_reg.kind == nvp_pkg::NVP_CMD_WRITE) begin
                            st_next.we_n = 1'b0;
                            st_next.oe_n = 1'b1;
                            tmr_len      = WRITE_LEN;
                        end else begin
                            st_next.we_n = 1'b1;
                            st_next.oe_n = 1'b0;
                            tmr_len      = READ_LEN;
                        end
                        st_next.state = nvp_pkg::NVP_STROBE;
                        tmr_start     = 1'b1;
                    end
                end
                nvp_pkg::NVP_STROBE: begin
                    if (tmr_tick) begin
                        if (st_reg.kind == nvp_pkg::NVP_CMD_READ) begin
                            // bytes not selected float; report them as zero
                            st_next.rdata = {st_reg.byte_en[1] ? data_pins_in[15:8] : 8'h00,
                                             st_reg.byte_en[0] ? data_pins_in[7:0] : 8'h00};
                        end
                        // all strobes rise together, ending the write
                        st_next.sel_u_n = 1'b1;
                        st_next.sel_l_n = 1'b1;
                        st_next.we_n    = 1'b1;
                        st_next.oe_n    = 1'b1;
                        st_next.state   = nvp_pkg::NVP_RECOVER;
                        tmr_start       = 1'b1;
                        tmr_len         = RECOVER_LEN;
                    end
                end
                nvp_pkg::NVP_RECOVER: begin
                    // address and write data held to here for hold time
                    if (tmr_tick) begin
                        st_next.drive_n = 1'b1;
                        if (st_reg.kind == nvp_pkg::NVP_CMD_PROTECT &&
                            st_reg.step != LAST_STEP) begin
                            // reads only, back to back: no write breaks the match
                            st_next.step  = st_reg.step + nvp_pkg::STEP_W'(1);
                            st_next.addr  = prog_addr(st_reg.step + nvp_pkg::STEP_W'(1),
                                                      st_reg.mask);
                            st_next.state = nvp_pkg::NVP_SETUP;
                            tmr_start     = 1'b1;
                            tmr_len       = SETUP_LEN;
                        end else begin
                            st_next.state     = nvp_pkg::NVP_IDLE;
                            st_next.rsp_valid = 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_reg         <= '0;
            st_reg.state   <= nvp_pkg::NVP_IDLE;
            st_reg.kind    <= nvp_pkg::NVP_CMD_NONE;
            st_reg.sel_u_n <= 1'b1;
            st_reg.sel_l_n <= 1'b1;
            st_reg.we_n    <= 1'b1;
            st_reg.oe_n    <= 1'b1;
            st_reg.drive_n <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign cmd_ready_out           = (st_reg.state == nvp_pkg::NVP_IDLE) && power_good_in;
    assign rsp_valid_out           = st_reg.rsp_valid;
    assign rsp_abort_out           = st_reg.rsp_abort;
    // programming reads never update rdata, so their data is dropped
    assign rsp_rdata_out           = st_reg.rdata;
    assign word_address_pins_out   = st_reg.addr;
    assign upper_byte_select_n_out = st_reg.sel_u_n;
    assign lower_byte_select_n_out = st_reg.sel_l_n;
    assign write_strobe_n_out      = st_reg.we_n;
    assign output_drive_n_out      = st_reg.oe_n;
    assign data_pins_out           = st_reg.wdata;
    assign data_pins_oe_n_out      = st_reg.drive_n;

endmodule

// [dv/nvp_host_port_properties.sv]
// pin-level assertions for the nv sram host port
`timescale 1ns/100ps
module nvp_chk #(
    parameter int ADDR_W = 17
) (
    // clock and reset
    input wire logic              clk_in,
    input wire logic              rst_in,
    // user side
    input wire logic              cmd_valid_in,
    input wire logic              cmd_ready_out,
    input wire logic [1:0]        cmd_kind_in,
    input wire logic [ADDR_W-1:0] cmd_addr_in,
    input wire logic [1:0]        cmd_byte_en_in,
    input wire logic              rsp_valid_out,
    input wire logic              power_good_in,
    // memory pins
    input wire logic [ADDR_W-1:0] word_address_pins_out,
    input wire logic              upper_byte_select_n_out,
    input wire logic              lower_byte_select_n_out,
    input wire logic              write_strobe_n_out,
    input wire logic              output_drive_n_out,
    input wire logic              data_pins_oe_n_out
);
    // ************************************************************
    // helpers and properties
    // ************************************************************
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    wire take_rw = cmd_valid_in && cmd_ready_out && !cmd_kind_in[1];
    wire take_wr = take_rw && cmd_kind_in[0];
    wire sel_any = !upper_byte_select_n_out || !lower_byte_select_n_out;
    // read strobe stands 15 cycles, write strobe 11
    sequence s_rd_low; (!output_drive_n_out)[*8] ##1 (!output_drive_n_out)[*7]; endsequence
    sequence s_wr_low; (!write_strobe_n_out)[*8] ##1 (!write_strobe_n_out)[*3]; endsequence
    // a supply drop aborts a cycle early, so those attempts are dropped
    property p_rd_len;
        disable iff (rst_in || !power_good_in) $fell(output_drive_n_out) |->
            ((write_strobe_n_out && sel_any) throughout s_rd_low) ##1 output_drive_n_out;
    endproperty
    a_rd_len: assert property (p_rd_len) else $error("read strobe shape wrong");
    property p_wr_len;
        disable iff (rst_in || !power_good_in) $fell(write_strobe_n_out) |->
            ((sel_any && output_drive_n_out) throughout s_wr_low) ##1 write_strobe_n_out;
    endproperty
    a_wr_len: assert property (p_wr_len) else $error("write strobe shape wrong");
    property p_wr_end; $rose(write_strobe_n_out) |-> !sel_any; endproperty
    a_wr_end: assert property (p_wr_end) else $error("write end not together");
    property p_addr_hold; sel_any && $past(sel_any) |-> $stable(word_address_pins_out); endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved in cycle");
    property p_no_contend; !data_pins_oe_n_out |-> output_drive_n_out; endproperty
    a_no_contend: assert property (p_no_contend) else $error("both sides drive data");
    property p_sel_width;
        $past(take_rw, 2) |-> {upper_byte_select_n_out, lower_byte_select_n_out} ==
            ~(($past(cmd_byte_en_in, 2) == 2'h0) ? 2'h3 : $past(cmd_byte_en_in, 2));
    endproperty
    a_sel_width: assert property (p_sel_width) else $error("byte selects wrong");
    property p_addr_pins;
        $past(take_rw) |-> word_address_pins_out == $past(cmd_addr_in);
    endproperty
    a_addr_pins: assert property (p_addr_pins) else $error("address pins wrong");
    property p_wr_rsp;
        disable iff (rst_in || !power_good_in) take_wr |-> ##23 rsp_valid_out;
    endproperty
    a_wr_rsp: assert property (p_wr_rsp) else $error("write answer late");
    property p_pwr;
        !power_good_in |=> upper_byte_select_n_out && lower_byte_select_n_out &&
            write_strobe_n_out && data_pins_oe_n_out;
    endproperty
    a_pwr: assert property (p_pwr) else $error("pins active with supply bad");
endmodule

// [dv/nvp_sram_model.sv]
// behavioural partitioned nv sram driven through its pins
`timescale 1ns/100ps
module nvp_sram_model (
    // memory pins
    input  wire logic [16:0] addr_in,
    input  wire logic        upper_n_in,
    input  wire logic        lower_n_in,
    input  wire logic        write_n_in,
    input  wire logic        drive_n_in,
    input  wire logic [15:0] bus_in,
    output logic      [15:0] bus_out,
    output logic             bus_drive_out,
    // supply monitor
    input  wire logic        power_good_in
);
    // ************************************************************
    // storage, matcher and pin behaviour
    // ************************************************************
    logic [15:0] mem [0:131071];
    logic [3:0]  pat [0:19] = '{4'hF, 4'hE, 4'h7, 4'h7, 4'h3, 4'h9, 4'hC, 4'hE, 4'h7, 4'h3,
                                4'h9, 4'h4, 4'h2, 4'h4, 4'hA, 4'h6, 4'h9, 4'h1, 4'h0, 4'h5};
    logic [15:0] prot = 16'h0000;   // retained; only a full load changes it
    logic [15:0] shadow;
    logic [16:0] wa, ra;
    logic [1:0]  wb, rb;
    logic [15:0] fl = 16'hA5C3;
    int          step = 0;
    // every input is ignored while the supply is bad
    wire sel = power_good_in && !(upper_n_in && lower_n_in);
    wire wr  = sel && !write_n_in;
    wire rd  = sel && write_n_in;
    assign bus_drive_out = rd && !drive_n_in;
    // a floating byte shows a changing level, never the last value
    assign bus_out = bus_drive_out ? {upper_n_in ? fl[15:8] : mem[addr_in][15:8],
                                      lower_n_in ? fl[7:0] : mem[addr_in][7:0]} : fl;
    always @(negedge bus_drive_out) fl = ~fl;
    // write flags at start, data taken at the first rising strobe
    always @(posedge wr) begin
        wa = addr_in;
        wb = {!upper_n_in, !lower_n_in};
        step = 0;
    end
    always @(negedge wr) begin
        if (power_good_in && !prot[wa[16:13]]) begin
            if (wb[1]) mem[wa][15:8] = bus_in[15:8];
            if (wb[0]) mem[wa][7:0] = bus_in[7:0];
        end
    end
    always @(posedge rd) begin
        ra = addr_in;
        rb = {!upper_n_in, !lower_n_in};
    end
    // matcher steps at the end of each read
    always @(negedge rd) begin
        if (power_good_in && write_n_in) begin
            if (step >= 20) begin
                shadow[(step-20)*4 +: 4] = ra[16:13];
                if (step == 23) prot = shadow;
                step = (step == 23) ? 0 : step + 1;
            end else if (rb == 2'h3 && ra[16:13] == pat[step]) step = step + 1;
            else step = (rb == 2'h3 && ra[16:13] == pat[0]) ? 1 : 0;
        end
    end
endmodule

// [dv/tb_top.sv]
// self-checking bench for the host port against the memory model
`timescale 1ns/100ps
module tb_top;
    // ************************************************************
    // signals, instances and shared tasks
    // ************************************************************
    localparam logic [1:0] RD = nvp_pkg::NVP_CMD_READ;
    localparam logic [1:0] WR = nvp_pkg::NVP_CMD_WRITE;
    localparam logic [1:0] PR = nvp_pkg::NVP_CMD_PROTECT;
    logic        clk_in = 0, rst_in = 1, cmd_valid_in = 0, power_good_in = 1, ab;
    logic [1:0]  cmd_kind_in = 2'h3, cmd_byte_en_in = 2'h3;
    logic [16:0] cmd_addr_in = 17'h00000;
    logic [15:0] cmd_wdata_in = 16'h0000, cmd_protect_mask_in = 16'h0000, rd;
    wire  [15:0] rsp_rdata_out, hd, mq, bus;
    wire  [16:0] word_address_pins_out;
    wire         cmd_ready_out, rsp_valid_out, rsp_abort_out, mdrv, data_pins_oe_n_out;
    wire         upper_byte_select_n_out, lower_byte_select_n_out;
    wire         write_strobe_n_out, output_drive_n_out;
    int          fail_count = 0, check_count = 0, cycles = 0;
    // released data lines take the model's changing float pattern
    assign bus = mdrv ? mq : (!data_pins_oe_n_out ? hd : mq);
    nvp_host_port nvp_host_port_i (.clk_in, .rst_in, .cmd_valid_in, .cmd_ready_out, .cmd_kind_in,
        .cmd_addr_in, .cmd_wdata_in, .cmd_byte_en_in, .cmd_protect_mask_in, .rsp_valid_out,
        .rsp_abort_out, .rsp_rdata_out, .power_good_in, .word_address_pins_out,
        .upper_byte_select_n_out, .lower_byte_select_n_out, .write_strobe_n_out,
        .output_drive_n_out, .data_pins_in(bus), .data_pins_out(hd), .data_pins_oe_n_out);
    nvp_sram_model nvp_sram_model_i (.addr_in(word_address_pins_out),
        .upper_n_in(upper_byte_select_n_out), .lower_n_in(lower_byte_select_n_out),
        .write_n_in(write_strobe_n_out), .drive_n_in(output_drive_n_out), .bus_in(bus),
        .bus_out(mq), .bus_drive_out(mdrv), .power_good_in);
    initial forever #2.5 clk_in = ~clk_in;
    task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    // one command start to answer; drop > 0 cuts the supply that many cycles in
    task automatic cmd(input logic [1:0] k, input logic [16:0] a, input logic [15:0] d,
                       input logic [1:0] be, input int drop);
        int n;
        @(negedge clk_in);
        cmd_kind_in = k;
        cmd_addr_in = a;
        cmd_wdata_in = d;
        cmd_protect_mask_in = d;
        cmd_byte_en_in = be;
        cmd_valid_in = 1;
        n = 0;
        while (cmd_ready_out !== 1'b1 && n < 50) begin
            @(negedge clk_in);
            n++;
        end
        @(negedge clk_in);
        cmd_valid_in = 0;
        repeat (drop) @(negedge clk_in);
        if (drop > 0) power_good_in = 0;
        n = 0;
        while (rsp_valid_out !== 1'b1 && n < 700) begin
            @(negedge clk_in);
            n++;
        end
        chk(rsp_valid_out, 1'b1);
        rd = rsp_rdata_out;
        ab = rsp_abort_out;
    endtask
    task automatic results;
        $display("checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_bytes;
        // kind three asks for nothing: no strobe may follow
        cmd_valid_in = 1;
        repeat (3) @(negedge clk_in);
        chk(upper_byte_select_n_out, 1'b1);
        cmd_valid_in = 0;
        cmd(WR, 17'h00123, 16'h1234, 2'h3, 0);
        cmd(RD, 17'h00123, 16'h0000, 2'h3, 0);
        chk(rd, 16'h1234);
        cmd(WR, 17'h00123, 16'hAB00, 2'h2, 0);
        cmd(WR, 17'h00123, 16'hFFCD, 2'h1, 0);
        cmd(WR, 17'h10123, 16'h5A5A, 2'h0, 0);
        cmd(RD, 17'h00123, 16'h0000, 2'h3, 0);
        chk(rd, 16'hABCD);
        cmd(RD, 17'h00123, 16'h0000, 2'h2, 0);
        chk(rd, 16'hAB00);
        cmd(RD, 17'h10123, 16'h0000, 2'h1, 0);
        chk(rd, 16'h005A);
    endtask
    // one protected partition per nibble so each load read is seen
    task automatic t_protect;
        logic [15:0] m;
        m = 16'h8421;
        cmd(PR, 17'h00000, 16'h0000, 2'h3, 0);
        for (int p = 0; p < 16; p++) cmd(WR, {p[3:0], 13'h0042}, 16'h1100 + p, 2'h3, 0);
        cmd(RD, 17'h00042, 16'h0000, 2'h3, 0);
        cmd(PR, 17'h00000, m, 2'h3, 0);
        chk(rd, 16'h1100);
        for (int p = 0; p < 16; p++) cmd(WR, {p[3:0], 13'h0042}, 16'hE000 + p, 2'h3, 0);
        for (int p = 0; p < 16; p++) begin
            cmd(RD, {p[3:0], 13'h0042}, 16'h0000, 2'h3, 0);
            chk(rd, m[p] ? 16'h1100 + p : 16'hE000 + p);
        end
        cmd(PR, 17'h00000, 16'h0000, 2'h3, 0);
        cmd(WR, 17'h00042, 16'h7777, 2'h3, 0);
        cmd(RD, 17'h00042, 16'h0000, 2'h3, 0);
        chk(rd, 16'h7777);
    endtask
    task automatic t_power;
        cmd(WR, 17'h00300, 16'h3C3C, 2'h3, 0);
        cmd(RD, 17'h00300, 16'h0000, 2'h3, 5);
        chk(ab, 1'b1);
        repeat (3) @(negedge clk_in);
        chk(cmd_ready_out, 1'b0);
        power_good_in = 1;
        cmd(WR, 17'h00300, 16'hDEAD, 2'h3, 2);
        chk(ab, 1'b1);
        power_good_in = 1;
        cmd(RD, 17'h00300, 16'h0000, 2'h3, 0);
        chk({ab, rd}, {1'b0, 16'h3C3C});
    endtask
    // hang guard well above the few thousand cycles the run needs
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            results();
        end
    end
    initial begin
        repeat (6) @(negedge clk_in);
        rst_in = 0;
        t_bytes();
        t_protect();
        t_power();
        results();
    end
endmodule
bind nvp_host_port nvp_chk #(.ADDR_W(ADDR_W)) nvp_chk_i (.clk_in, .rst_in, .cmd_valid_in,
    .cmd_ready_out, .cmd_kind_in, .cmd_addr_in, .cmd_byte_en_in, .rsp_valid_out, .power_good_in,
    .word_address_pins_out, .upper_byte_select_n_out, .lower_byte_select_n_out,
    .write_strobe_n_out, .output_drive_n_out, .data_pins_oe_n_out);
